// ==== core/parallel_io_line_controller.sv ====
// Parallel I/O line controller with an AHB-Lite register slave.
//
// The implementer's own choices: the address map and register access over AHB-Lite.
`timescale 1ns/10ps

// Behaviour
// - Thirty-two lines, six dedicated, rest shared.
// - One level interrupt output to controller.
// - Reset: controller-owned inputs, some peripheral-owned.
// - Controller-owned lines work in both directions.
// - Select command gives pin, release returns it.
// - Ownership status readable per line.
// - Dedicated lines ignore select/release commands, read one.
// - Peripheral input held zero while controller owns.
// - Enable/disable commands set direction; status readable.
// - Direction matters only under controller ownership.
// - Set/clear commands drive output high/low.
// - Programmed level readable as status.
// - Controller-owned input leaves pin undriven.
// - Peripheral ownership routes its output and enable.
// - Actual pin levels always readable.
// - Pin change sets status; masked irq asserts.
// - Reading event status clears it.
// - Unimplemented lines ignore writes, read zero.
module parallel_io_line_controller
   import pio_line_pkg::*;
#(
   parameter int          NUM_LINES  = LINES,
   parameter logic [31:0] LINE_IMPL  = IMPL_LINES
) (
   // Clock, reset and enable
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        clk_en,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Pins
   input  wire logic [31:0] pin_in,
   output logic      [31:0] pin_out,
   output logic      [31:0] pin_oe,
   // Peripheral side
   input  wire logic [31:0] periph_out,
   input  wire logic [31:0] periph_oe,
   output logic      [31:0] periph_in,
   // Interrupt
   output logic             irq
);

   initial begin
      if (NUM_LINES != LINES) begin
         $error("Only 32 lines are supported.");
      end
   end

   // Register state.
   logic [31:0] owner;
   logic [31:0] dir;
   logic [31:0] level;
   logic [31:0] evt_mask;
   logic [31:0] evt_stat;
   logic [31:0] pin_prev;
   logic        pin_valid;

   // Bus address phase capture.
   logic        dp_write;
   logic        dp_read;
   logic [7:0]  dp_addr;

   wire         access    = hsel & hready & (htrans == HTRANS_NONSEQ);
   wire         wr_phase  = clk_en & dp_write;
   wire         rd_phase  = clk_en & dp_read;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      return a == o;
   endfunction

   wr_strobe_t  strb;
   assign strb.own_sel  = wr_phase & hit(dp_addr, OFS_OWN_SEL);
   assign strb.own_rel  = wr_phase & hit(dp_addr, OFS_OWN_REL);
   assign strb.oe_set   = wr_phase & hit(dp_addr, OFS_OE_SET);
   assign strb.oe_clr   = wr_phase & hit(dp_addr, OFS_OE_CLR);
   assign strb.drv_high = wr_phase & hit(dp_addr, OFS_DRV_HIGH);
   assign strb.drv_low  = wr_phase & hit(dp_addr, OFS_DRV_LOW);
   assign strb.irq_en   = wr_phase & hit(dp_addr, OFS_IRQ_EN);
   assign strb.irq_dis  = wr_phase & hit(dp_addr, OFS_IRQ_DIS);

   // Bits of missing lines never take a write.
   wire [31:0]  wdata     = hwdata & LINE_IMPL;
   wire [31:0]  shared    = LINE_IMPL & ~DEDICATED_LINES;

   wire [31:0]  next_owner_raw =
      (owner | (strb.own_sel ? wdata : 32'h0000_0000))
      & ~(strb.own_rel ? wdata : 32'h0000_0000);
   wire [31:0]  next_owner = (next_owner_raw & shared)
                             | (DEDICATED_LINES & LINE_IMPL);

   wire [31:0]  next_dir =
      (dir | (strb.oe_set ? wdata : 32'h0000_0000))
      & ~(strb.oe_clr ? wdata : 32'h0000_0000);

   // Level commands; the stored level is kept for any direction.
   wire [31:0]  next_level =
      (level | (strb.drv_high ? wdata : 32'h0000_0000))
      & ~(strb.drv_low ? wdata : 32'h0000_0000);

   wire [31:0]  next_mask =
      (evt_mask | (strb.irq_en ? wdata : 32'h0000_0000))
      & ~(strb.irq_dis ? wdata : 32'h0000_0000);

   // Any level change on an implemented pin is an event.
   wire [31:0]  change = pin_valid ? ((pin_in ^ pin_prev) & LINE_IMPL)
                                   : 32'h0000_0000;
   wire         stat_rd  = rd_phase & hit(dp_addr, OFS_IRQ_STAT);
   // Read clears; a change in the same cycle survives.
   wire [31:0]  next_stat = (stat_rd ? 32'h0000_0000 : evt_stat) | change;

   pad_drive_t  pad;
   assign pad.out = (next_owner & next_level) | (~next_owner & periph_out);
   assign pad.oe  = ((next_owner & next_dir) | (~next_owner & periph_oe))
                    & LINE_IMPL;

   // Read data selection on the address phase.
   // The event status read takes this cycle's change as well, because
   // the clear at the end of the data phase drops everything held.
   wire [7:0]   ap_addr  = haddr[7:0];
   wire [31:0]  rd_value =
      hit(ap_addr, OFS_OWN_STAT) ? owner :
      hit(ap_addr, OFS_DIR_STAT) ? dir :
      hit(ap_addr, OFS_LVL_STAT) ? level :
      hit(ap_addr, OFS_PIN_STAT) ? (pin_in & LINE_IMPL) :
      hit(ap_addr, OFS_IRQ_MASK) ? evt_mask :
      hit(ap_addr, OFS_IRQ_STAT) ? next_stat : 32'h0000_0000;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_write <= 1'b0;
         dp_read  <= 1'b0;
         dp_addr  <= 8'h00;
      end else if (clk_en) begin
         dp_write <= access & hwrite;
         dp_read  <= access & ~hwrite;
         dp_addr  <= haddr[7:0];
      end
   end

   // Slave answers with zero wait states; a frozen clock enable holds it.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else if (clk_en) begin
         hrdata    <= (access & ~hwrite) ? rd_value : hrdata;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         owner    <= OWN_RESET & LINE_IMPL;
         dir      <= DIR_RESET;
         level    <= LVL_RESET;
         evt_mask <= MASK_RESET;
      end else if (clk_en) begin
         owner    <= next_owner;
         dir      <= next_dir;
         level    <= next_level;
         evt_mask <= next_mask;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         evt_stat  <= 32'h0000_0000;
         pin_prev  <= 32'h0000_0000;
         pin_valid <= 1'b0;
      end else if (clk_en) begin
         evt_stat  <= next_stat;
         pin_prev  <= pin_in;
         pin_valid <= 1'b1;
      end
   end

   // Outputs are registered from the next-state values, so pins follow a command on the same edge that stores it.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_out   <= 32'h0000_0000;
         pin_oe    <= 32'h0000_0000;
         periph_in <= 32'h0000_0000;
         irq       <= 1'b0;
      end else if (clk_en) begin
         // Drive from whichever side owns each line.
         pin_out   <= pad.out;
         pin_oe    <= pad.oe;
         // Peripheral sees zero on controller-owned lines.
         periph_in <= pin_in & ~next_owner & LINE_IMPL;
         // Level interrupt from enabled status bits.
         irq       <= |(next_stat & next_mask);
      end
   end

endmodule

// ==== core/pio_line_pkg.sv ====
// Package holding the register map, reset values and line layout of the I/O controller.
package pio_line_pkg;

   localparam int          LINES            = 32;
   localparam logic [7:0]  OFS_OWN_SEL      = 8'h00;
   localparam logic [7:0]  OFS_OWN_REL      = 8'h04;
   localparam logic [7:0]  OFS_OWN_STAT     = 8'h08;
   localparam logic [7:0]  OFS_OE_SET       = 8'h10;
   localparam logic [7:0]  OFS_OE_CLR       = 8'h14;
   localparam logic [7:0]  OFS_DIR_STAT     = 8'h18;
   localparam logic [7:0]  OFS_DRV_HIGH     = 8'h30;
   localparam logic [7:0]  OFS_DRV_LOW      = 8'h34;
   localparam logic [7:0]  OFS_LVL_STAT     = 8'h38;
   localparam logic [7:0]  OFS_PIN_STAT     = 8'h3C;
   localparam logic [7:0]  OFS_IRQ_EN       = 8'h40;
   localparam logic [7:0]  OFS_IRQ_DIS      = 8'h44;
   localparam logic [7:0]  OFS_IRQ_MASK     = 8'h48;
   localparam logic [7:0]  OFS_IRQ_STAT     = 8'h4C;

   // Lines 16..19, 23 and 24 have no peripheral behind them.
   localparam logic [31:0] DEDICATED_LINES  = 32'h018F_0000;
   localparam logic [31:0] OWN_RESET        = 32'h01FF_FFFF;
   localparam logic [31:0] IMPL_LINES       = 32'hFFFF_FFFF;
   localparam logic [31:0] DIR_RESET        = 32'h0000_0000;
   localparam logic [31:0] LVL_RESET        = 32'h0000_0000;
   localparam logic [31:0] MASK_RESET       = 32'h0000_0000;

   localparam logic [1:0]  HTRANS_NONSEQ    = 2'b10;
   localparam logic [2:0]  HSIZE_WORD       = 3'b010;

   // One decoded bus write: which command register is written.
   typedef struct packed {
      logic        own_sel;
      logic        own_rel;
      logic        oe_set;
      logic        oe_clr;
      logic        drv_high;
      logic        drv_low;
      logic        irq_en;
      logic        irq_dis;
   } wr_strobe_t;

   // Pad-side signals of one peripheral, or of the pins.
   typedef struct packed {
      logic [31:0] out;
      logic [31:0] oe;
   } pad_drive_t;

endpackage

// ==== verif/parallel_io_line_controller_test.sv ====
// Self-checking bench of the I/O controller.
`timescale 1ns/10ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; \
   $display("ERROR %0t got %h want %h", $time, a, b); end end
module parallel_io_line_controller_test;
   import pio_line_pkg::*;
   typedef struct {logic [7:0] a; logic [31:0] d, oe, out;} row_t;
   logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
   logic [1:0]  htrans = 2'b00;
   logic [31:0] haddr = 0, hwdata = 0, ext = 0, rd;
   logic [31:0] p_out = 32'hA5A5_A5A5, p_oe = 32'hFFFF_FFFF;
   wire  [31:0] hrdata, pin_in, pin_out, pin_oe, periph_in;
   wire         hreadyout, hresp, irq;
   int          error_cnt = 0, cmp_count = 0;
   row_t rows[7] = '{
      '{OFS_OE_SET,   32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hA400_0000},
      '{OFS_DRV_HIGH, 32'h0000_00FF, 32'hFFFF_FFFF, 32'hA400_00FF},
      '{OFS_DRV_LOW,  32'h0000_000F, 32'hFFFF_FFFF, 32'hA400_00F0},
      '{OFS_OWN_REL,  32'h00FF_0001, 32'hFFFF_FFFF, 32'hA420_00F1},
      '{OFS_OE_CLR,   32'h0000_00F0, 32'hFFFF_FF0F, 32'hA420_0001},
      '{OFS_OWN_SEL,  32'hFFFF_FFFF, 32'hFFFF_FF0F, 32'h0000_0000},
      '{8'h0C,        32'hFFFF_FFFF, 32'hFFFF_FF0F, 32'h0000_0000}};
   always #2.5 hclk = ~hclk;
   parallel_io_line_controller dut_u (.hclk(hclk), .hresetn(hresetn),
      .clk_en(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(HSIZE_WORD), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .periph_out(p_out), .periph_oe(p_oe), .periph_in(periph_in),
      .irq(irq));
   pio_pad_model pad_u (.pin_out(pin_out), .pin_oe(pin_oe),
      .ext_level(ext), .pin_in(pin_in));
   task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge hclk);
      {hsel, hwrite, htrans, haddr} <= {1'b1, w, HTRANS_NONSEQ, 24'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      {hsel, htrans, hwdata} <= {1'b0, 2'b00, d};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic settle();
      repeat (3) @(posedge hclk);
      #1;
   endtask
   task automatic stop_test();
      $display("errors %0d compares %0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      #40000;
      error_cnt++;
      stop_test();
   end
   initial begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      settle();
      `CHK(pin_oe, 32'hFE00_0000)
      `CHK(periph_in, 32'hA400_0000)
      `CHK(hresp, 1'b0)
      bus(0, OFS_OWN_STAT, 0);
      `CHK(rd, OWN_RESET)
      foreach (rows[i]) begin
         bus(1, rows[i].a, rows[i].d);
         settle();
         `CHK(pin_oe, rows[i].oe)
         `CHK(pin_out & pin_oe, rows[i].out)
      end
      bus(0, OFS_OWN_STAT, 0);
      `CHK(rd, 32'hFFFF_FFFF)
      bus(0, OFS_LVL_STAT, 0);
      `CHK(rd, 32'h0000_00F0)
      bus(0, OFS_DIR_STAT, 0);
      `CHK(rd, 32'hFFFF_FF0F)
      `CHK(periph_in, 32'h0000_0000)
      ext <= 32'h0000_0050;
      bus(0, OFS_PIN_STAT, 0);
      `CHK(rd, 32'h0000_0050)
      bus(0, OFS_IRQ_STAT, 0);
      bus(1, OFS_IRQ_EN, 32'h0000_0010);
      bus(0, OFS_IRQ_MASK, 0);
      `CHK(rd, 32'h0000_0010)
      ext <= 32'h0000_0040;
      settle();
      `CHK(irq, 1'b1)
      bus(0, OFS_IRQ_STAT, 0);
      `CHK(rd, 32'h0000_0010)
      settle();
      `CHK(irq, 1'b0)
      bus(1, OFS_IRQ_DIS, 32'h0000_0010);
      ext <= 32'h0000_0050;
      settle();
      `CHK(irq, 1'b0)
      bus(1, OFS_IRQ_EN, 32'h0000_0010);
      settle();
      `CHK(irq, 1'b1)
      stop_test();
   end
endmodule

// ==== verif/pio_line_monitor.sv ====
// Checker for bus, pad and interrupt timing of the I/O controller.
`timescale 1ns/10ps
module pio_line_monitor
   import pio_line_pkg::*;
(
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        clk_en,
   input wire logic        hsel,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] pin_in,
   input wire logic [31:0] pin_oe,
   input wire logic [31:0] periph_oe,
   input wire logic [31:0] periph_in,
   input wire logic        irq
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_wr;
      hsel && hready && hwrite && htrans == HTRANS_NONSEQ && clk_en;
   endsequence
   property p_okay; hreadyout && !hresp; endproperty
   a_okay: assert property (p_okay) else $error("bus not ready");
   property p_wr; s_wr |=> hreadyout ##1 hreadyout; endproperty
   a_wr: assert property (p_wr) else $error("write stalled");
   property p_pin; $past(clk_en) |-> (periph_in & ~$past(pin_in)) == 0;
   endproperty
   a_pin: assert property (p_pin) else $error("peripheral input");
   property p_ded; (periph_in & DEDICATED_LINES) == 32'h0000_0000;
   endproperty
   a_ded: assert property (p_ded) else $error("dedicated input");
   // Drive changes come only from a command, the peripheral's own enable or reset.
   property p_oe; $changed(pin_oe) |-> $past(hsel && hwrite, 2) ||
      $past(periph_oe) != $past(periph_oe, 2) || !$past(hresetn, 2);
   endproperty
   a_oe: assert property (p_oe) else $error("pin enable moved");
   property p_drv; $changed(pin_oe & DEDICATED_LINES) |->
      $past(hsel && hwrite, 2) || !$past(hresetn, 2); endproperty
   a_drv: assert property (p_drv) else $error("dedicated enable");
   property p_rise; $rose(irq) |-> $past(pin_in, 1) != $past(pin_in, 2)
      || $past(hsel && hwrite, 2); endproperty
   a_rise: assert property (p_rise) else $error("irq without event");
   property p_fall; $fell(irq) |-> $past(hsel && htrans[1], 2); endproperty
   a_fall: assert property (p_fall) else $error("irq fell alone");
endmodule
bind parallel_io_line_controller pio_line_monitor mon_u (.*);

// ==== verif/pio_pad_model.sv ====
// Pin-side model: external circuitry that holds each undriven pin.
`timescale 1ns/10ps
module pio_pad_model (
   // Device drive
   input  wire logic [31:0] pin_out,
   input  wire logic [31:0] pin_oe,
   // External level on lines that the device leaves alone
   input  wire logic [31:0] ext_level,
   // Resolved pin level
   output logic      [31:0] pin_in
);
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule
